//--- src/wgu_unit.v
// Eight-channel waveform GPIO unit with direct and generated outputs
`timescale 1ns/1ps
`include "wgu_defs.vh"

////////////////////////////////////////////////////////////////////////////
module wgu_unit (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [`WGU_AW-1:0] reg_addr_i,
    input wire [`WGU_DW-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [`WGU_DW-1:0] reg_rdata_o,
    input wire [`WGU_NCH-1:0] pin_i,
    output reg [`WGU_NCH-1:0] pin_o,
    output reg [`WGU_NCH-1:0] pin_oe_o,
    output reg irq_o
);

////////////////////////////////////////////////////////////////////////////
// Register file
reg unit_run;
reg [`WGU_NCH-1:0] direct_level;
reg [`WGU_NCH-1:0] irq_mask;
reg [`WGU_NCH-1:0] irq_stat;
reg [`WGU_NCH-1:0] running;
reg [`WGU_NCH-1:0] pin_meta;
reg [`WGU_NCH-1:0] pin_sync;
reg [`WGU_DW-1:0] shape [0:`WGU_NCH-1];
reg [`WGU_CW-1:0] repeat_cnt [0:`WGU_NCH-1];

wire [`WGU_NCH-1:0] wave_level;
wire [`WGU_NCH-1:0] wave_done;
wire [2:0] ch_idx;
wire shape_hit;
wire repeat_hit;
wire wr_start;
wire wr_stop;
wire rd_stat;

assign ch_idx = reg_addr_i[`WGU_IDX_MSB:`WGU_IDX_LSB];
assign shape_hit = (reg_addr_i & `WGU_BANK_MASK) == `WGU_SHAPE_BASE;
assign repeat_hit = (reg_addr_i & `WGU_BANK_MASK) == `WGU_REPEAT_BASE;
// Either controller shares this port; an arbiter outside serialises them
assign wr_start = reg_wr_i && reg_addr_i == `WGU_START;
assign wr_stop = reg_wr_i && reg_addr_i == `WGU_STOP;
assign rd_stat = reg_rd_i && reg_addr_i == `WGU_IRQ_STAT;

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        unit_run <= `WGU_CTRL_RST;
        direct_level <= `WGU_DIRECT_RST;
        pin_oe_o <= `WGU_OUT_EN_RST;
        irq_mask <= `WGU_MASK_RST;
    end else if (reg_wr_i) begin
        case (reg_addr_i)
            `WGU_CTRL: unit_run <= reg_wdata_i[`WGU_CTRL_RUN];
            `WGU_DIRECT: direct_level <= reg_wdata_i[`WGU_NCH-1:0];
            `WGU_OUT_EN: pin_oe_o <= reg_wdata_i[`WGU_NCH-1:0];
            `WGU_IRQ_MASK: irq_mask <= reg_wdata_i[`WGU_NCH-1:0];
            default: ;
        endcase
    end
end

// Shape and repeat banks
always @(posedge clk_i) begin
    if (sys_rst_i) begin : clr
        integer k;
        for (k = 0; k < `WGU_NCH; k = k + 1) begin
            shape[k] <= `WGU_SHAPE_RST;
            repeat_cnt[k] <= `WGU_REPEAT_RST;
        end
    end else if (reg_wr_i && shape_hit) begin
        shape[ch_idx] <= reg_wdata_i;
    end else if (reg_wr_i && repeat_hit) begin
        repeat_cnt[ch_idx] <= reg_wdata_i[`WGU_CW-1:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// Run state: start, stop, self-termination
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        running <= {`WGU_NCH{1'b0}};
    end else if (!unit_run) begin
        // Stopped domain loses all generation state
        running <= {`WGU_NCH{1'b0}};
    end else begin
        running <= (running & ~wave_done
                    & ~(wr_stop ? reg_wdata_i[`WGU_NCH-1:0]
                                : {`WGU_NCH{1'b0}}))
                   | (wr_start ? reg_wdata_i[`WGU_NCH-1:0]
                               : {`WGU_NCH{1'b0}});
    end
end

////////////////////////////////////////////////////////////////////////////
// Per-channel generators
genvar g;
generate
    for (g = 0; g < `WGU_NCH; g = g + 1) begin : gen_ch
        reg [`WGU_CW-1:0] phase;
        reg [`WGU_CW-1:0] reps;
        wire [`WGU_CW-1:0] period;
        wire [`WGU_CW-1:0] high_len;
        wire start_now;
        wire wrap;

        assign period = shape[g][`WGU_PERIOD_MSB:`WGU_PERIOD_LSB];
        assign high_len = shape[g][`WGU_HIGH_MSB:`WGU_HIGH_LSB];
        assign start_now = unit_run && wr_start && reg_wdata_i[g];
        // Period of zero behaves as one clock
        assign wrap = period == {`WGU_CW{1'b0}} ||
                      phase == period - 16'h0001;
        assign wave_level[g] = phase < high_len;
        assign wave_done[g] = running[g] && wrap &&
                              repeat_cnt[g] != 16'h0000 &&
                              reps == repeat_cnt[g] - 16'h0001;

        always @(posedge clk_i) begin
            if (sys_rst_i || start_now || !running[g]) begin
                phase <= 16'h0000;
                reps <= 16'h0000;
            end else if (wrap) begin
                phase <= 16'h0000;
                reps <= reps + 16'h0001;
            end else begin
                phase <= phase + 16'h0001;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Pins, level mirror, notification
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        pin_meta <= {`WGU_NCH{1'b0}};
        pin_sync <= {`WGU_NCH{1'b0}};
        pin_o <= {`WGU_NCH{1'b0}};
        irq_stat <= {`WGU_NCH{1'b0}};
        irq_o <= 1'b0;
    end else begin
        pin_meta <= pin_i;
        pin_sync <= pin_meta;
        // One register stage per pin: at most one change per clock
        pin_o <= (running & wave_level)
                 | (~running & direct_level);
        // A done event in the clearing read cycle still lands
        irq_stat <= (rd_stat ? {`WGU_NCH{1'b0}} : irq_stat)
                    | wave_done;
        irq_o <= |(((rd_stat ? {`WGU_NCH{1'b0}} : irq_stat)
                    | wave_done) & irq_mask);
    end
end

////////////////////////////////////////////////////////////////////////////
// Read path, data in the cycle after the strobe
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        reg_rdata_o <= {`WGU_DW{1'b0}};
    end else if (!reg_rd_i) begin
        reg_rdata_o <= {`WGU_DW{1'b0}};
    end else if (shape_hit) begin
        reg_rdata_o <= shape[ch_idx];
    end else if (repeat_hit) begin
        reg_rdata_o <= {16'h0000, repeat_cnt[ch_idx]};
    end else begin
        case (reg_addr_i)
            `WGU_CTRL: reg_rdata_o <= {31'h0000_0000, unit_run};
            `WGU_DIRECT: reg_rdata_o <= {24'h00_0000, direct_level};
            `WGU_OUT_EN: reg_rdata_o <= {24'h00_0000, pin_oe_o};
            `WGU_START: reg_rdata_o <= {24'h00_0000, running};
            `WGU_LEVEL: reg_rdata_o <= {24'h00_0000, pin_sync};
            `WGU_IRQ_STAT: reg_rdata_o <= {24'h00_0000, irq_stat};
            `WGU_IRQ_MASK: reg_rdata_o <= {24'h00_0000, irq_mask};
            default: reg_rdata_o <= {`WGU_DW{1'b0}};
        endcase
    end
end

endmodule // wgu_unit

//--- src/wgu_defs.vh
// Register map, field layout and reset values of the waveform GPIO unit
`ifndef WGU_DEFS_VH
`define WGU_DEFS_VH

`define WGU_NCH 8
`define WGU_AW 8
`define WGU_DW 32
`define WGU_CW 16

// Byte addresses of the registers
`define WGU_CTRL 8'h00
`define WGU_DIRECT 8'h04
`define WGU_OUT_EN 8'h08
`define WGU_START 8'h0c
`define WGU_STOP 8'h10
`define WGU_LEVEL 8'h14
`define WGU_IRQ_STAT 8'h18
`define WGU_IRQ_MASK 8'h1c
`define WGU_SHAPE_BASE 8'h40
`define WGU_REPEAT_BASE 8'h60
`define WGU_BANK_MASK 8'he3
`define WGU_IDX_LSB 2
`define WGU_IDX_MSB 4

// Field positions
`define WGU_CTRL_RUN 0
`define WGU_PERIOD_LSB 0
`define WGU_PERIOD_MSB 15
`define WGU_HIGH_LSB 16
`define WGU_HIGH_MSB 31

// Reset values
`define WGU_CTRL_RST 1'b0
`define WGU_DIRECT_RST 8'h00
`define WGU_OUT_EN_RST 8'h00
`define WGU_MASK_RST 8'h00
`define WGU_SHAPE_RST 32'h0001_0002
`define WGU_REPEAT_RST 16'h0000

`endif

//--- tb/wgu_pad_model.sv
// Pad model: actuator feedback on undriven pins
`timescale 1ns/1ps
module wgu_pad_model (
    input wire [7:0] pin_o_i,
    input wire [7:0] pin_oe_i,
    input wire [7:0] ext_i,
    output wire [7:0] pad_o
);
    // Actuator drives only pins that the unit leaves floating
    assign pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule // wgu_pad_model

//--- tb/wgu_unit_chk.sv
// Port assertions for the waveform GPIO unit
`timescale 1ns/1ps
`include "wgu_defs.vh"
module wgu_unit_chk (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire [7:0] pin_i,
    input wire [7:0] pin_o,
    input wire [7:0] pin_oe_o,
    input wire irq_o
);
    reg [7:0] mask;
    reg gen;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Direct check only holds before any generator ran
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            mask <= 8'h00;
            gen <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `WGU_IRQ_MASK) begin
            mask <= reg_wdata_i[7:0];
        end else if (reg_wr_i && reg_addr_i == `WGU_START) begin
            gen <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("stray rdata");
    a_level_read: assert property (
        reg_rd_i && reg_addr_i == `WGU_LEVEL && $stable(pin_i)
        && $past(pin_i) == $past(pin_i, 2) && pin_i == $past(pin_i, 3)
        |=> reg_rdata_o == {24'h0, $past(pin_i)}) else $error("bad level");
    a_oe_write: assert property (
        reg_wr_i && reg_addr_i == `WGU_OUT_EN
        |=> pin_oe_o == $past(reg_wdata_i[7:0])) else $error("bad oe");
    a_oe_read: assert property (
        reg_rd_i && reg_addr_i == `WGU_OUT_EN
        |=> reg_rdata_o == {24'h0, pin_oe_o}) else $error("bad oe read");
    a_direct_drive: assert property (
        reg_wr_i && reg_addr_i == `WGU_DIRECT && !gen
        |-> ##2 pin_o == $past(reg_wdata_i[7:0], 2)) else $error("bad pin");
    a_irq_masked: assert property (
        mask == 8'h00 [*2] |-> !irq_o) else $error("masked irq");
    a_reset_quiet: assert property (
        $fell(sys_rst_i) |-> pin_oe_o == 8'h00 && !irq_o)
        else $error("driven after reset");
    a_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read");
endmodule // wgu_unit_chk

bind wgu_unit wgu_unit_chk u_chk (.clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_i, .pin_o,
    .pin_oe_o, .irq_o);

//--- tb/testbench.sv
// Self-checking bench for the waveform GPIO unit
`timescale 1ns/1ps
`include "wgu_defs.vh"
module testbench;
    reg clk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [7:0] reg_addr_i = 8'h00;
    reg [31:0] reg_wdata_i = 32'h0;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [7:0] ext = 8'h00;
    wire [31:0] reg_rdata_o;
    wire [7:0] pin_i, pin_o, pin_oe_o;
    wire irq_o;
    reg [7:0] wave;
    integer failures = 0;
    integer checks = 0;
    integer i;
    wgu_unit DUT (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .pin_i, .pin_o, .pin_oe_o, .irq_o);
    wgu_pad_model u_pad (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_i(ext),
        .pad_o(pin_i));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_i);
            reg_wr_i <= 1'b1;
            reg_addr_i <= a;
            reg_wdata_i <= v;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            @(posedge clk_i);
            reg_rd_i <= 1'b1;
            reg_addr_i <= a;
            @(posedge clk_i);
            reg_rd_i <= 1'b0;
            #1 chk(reg_rdata_o, e);
        end
    endtask
    task end_sim;
        begin
            $display("checks=%0d failures=%0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial forever #20 clk_i = ~clk_i;
    initial begin
        #200000 failures = failures + 1;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`WGU_OUT_EN, 32'h0);
        rd(`WGU_DIRECT, 32'h0);
        rd(`WGU_IRQ_MASK, 32'h0);
        rd(`WGU_SHAPE_BASE, `WGU_SHAPE_RST);
        rd(8'h20, 32'h0);
        wr(`WGU_OUT_EN, 32'hff);
        wr(`WGU_DIRECT, 32'ha5);
        repeat (2) @(posedge clk_i);
        #1 chk(pin_o, 8'ha5);
        wr(`WGU_DIRECT, 32'h5a);
        repeat (2) @(posedge clk_i);
        #1 chk(pin_o, 8'h5a);
        wr(`WGU_OUT_EN, 32'h0f);
        ext <= 8'h3c;
        repeat (4) @(posedge clk_i);
        rd(`WGU_LEVEL, 32'h3a);
        wr(`WGU_DIRECT, 32'h00);
        wr(`WGU_IRQ_MASK, 32'h01);
        wr(`WGU_CTRL, 32'h01);
        wr(`WGU_SHAPE_BASE, 32'h0001_0004);
        wr(`WGU_REPEAT_BASE, 32'h2);
        wr(`WGU_START, 32'h01);
        wr(`WGU_DIRECT, 32'h01);
        // Direct write lands mid-run, must not show until the end
        // Index i is the edge count after the start write
        for (i = 3; i <= 10; i = i + 1) begin
            @(posedge clk_i);
            #1 wave[i-3] = pin_o[0];
            if (i == 7) chk(irq_o, 1'b0);
            if (i == 8) chk(irq_o, 1'b1);
        end
        // High at edges 5, then direct level from edge 9 on
        chk(wave, 8'hc4);
        rd(`WGU_IRQ_STAT, 32'h1);
        chk(irq_o, 1'b0);
        rd(`WGU_IRQ_STAT, 32'h0);
        wr(`WGU_REPEAT_BASE, 32'h0);
        wr(`WGU_START, 32'h01);
        rd(`WGU_START, 32'h1);
        wr(`WGU_STOP, 32'h01);
        rd(`WGU_START, 32'h0);
        @(posedge clk_i);
        #1 chk(pin_o[0], 1'b1);
        // Unit switched off refuses new starts
        wr(`WGU_CTRL, 32'h00);
        rd(`WGU_CTRL, 32'h0);
        wr(`WGU_START, 32'h01);
        rd(`WGU_START, 32'h0);
        // Second reset with the unit switched off brings every register back
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`WGU_DIRECT, 32'h0);
        rd(`WGU_OUT_EN, 32'h0);
        #1 chk(pin_o, 8'h00);
        end_sim;
    end
endmodule // testbench
